/* File: design/sacc_ctrl.sv */
// Converter control: registers, sequencing, result formatting, wake and interrupt.
// Assumes a comparator core answering each trial bit within one half period.
//
// Local design decisions: the register addresses and the strobed register port.
`default_nettype none
`include "sacc_defs.svh"
module sacc_ctrl
    import sacc_pkg::*;
#(
    parameter int RES_W = 10
) (
    input wire logic clk,
    input wire logic srst,
    input wire sacc_bus_s bus,
    output logic [7:0] rdata,
    input wire logic sleeping,
    input wire logic rc_tick,
    input wire logic comp_in,
    input wire logic fvr_pin_ready,
    output sacc_analog_s analog,
    output logic [RES_W-1:0] trial,
    output logic sample,
    output logic int_req,
    output logic wake,
    output logic vector_req
);
    localparam int FVR_CYC = (`SACC_FVR_SETTLE_NS + `SACC_CLK_NS - 1) / `SACC_CLK_NS;
    logic [7:0] c0_reg, c1_reg, fv_reg, pe_reg, ic_reg;
    logic [7:0] c0_next, c1_next, fv_next;
    logic flag_reg, flag_next;
    logic [RES_W-1:0] sar_reg, sar_next, bit_reg, bit_next;
    logic [RES_W-1:0] res_reg, res_next;
    logic [4:0] half_reg, half_next;
    sacc_state_e st_reg, st_next;
    logic [7:0] rdy_cnt_reg;
    logic rdy_reg;
    logic cmp_s1_reg, cmp_s2_reg, slp_s1_reg, slp_s2_reg, pin_s1_reg, pin_s2_reg;
    logic half_tick;
    logic wr0, wr1, wrf, wrp, wre, wri, rc_sel, abort, done, go_set, go_clr;
    logic [7:0] resh, resl, rd_mux;
    sacc_analog_s analog_next;

    sacc_clkgen u_clk (
        .clk(clk),
        .srst(srst),
        .run(st_reg != SACC_IDLE),
        .sel(c1_reg[`SACC_B_CS +: 3]),
        .rc_tick(rc_tick),
        .half_tick(half_tick)
    );

    assign wr0 = bus.wr && (bus.addr == `SACC_OFS_CTRL0);
    assign wr1 = bus.wr && (bus.addr == `SACC_OFS_CTRL1);
    assign wrf = bus.wr && (bus.addr == `SACC_OFS_FVRC);
    assign wrp = bus.wr && (bus.addr == `SACC_OFS_PFLAG);
    assign wre = bus.wr && (bus.addr == `SACC_OFS_PEN);
    assign wri = bus.wr && (bus.addr == `SACC_OFS_INTC);
    assign rc_sel = (c1_reg[`SACC_B_CS +: 2] == 2'h3);
    assign abort = (slp_s2_reg && !rc_sel) || !c0_reg[`SACC_B_ON];
    assign go_set = wr0 && bus.wdata[`SACC_B_GO] && c0_reg[`SACC_B_ON] && !c0_reg[`SACC_B_GO];
    assign go_clr = wr0 && !bus.wdata[`SACC_B_GO];
    // 23 half periods is 11.5 periods
    assign done = (st_reg == SACC_CONV) && half_tick
                  && (half_reg == 5'(`SACC_HALF_PERIODS - 1));

    // Sequencer
    always_comb begin
        st_next = st_reg;
        half_next = half_reg;
        sar_next = sar_reg;
        bit_next = bit_reg;
        case (st_reg)
            SACC_IDLE: begin
                if (go_set && !abort) begin
                    st_next = rc_sel ? SACC_WAIT : SACC_CONV;
                    half_next = 5'h00;
                    sar_next = '0;
                    bit_next = {1'b1, {(RES_W-1){1'b0}}};
                end
            end
            SACC_WAIT: begin
                if (abort || go_clr) begin
                    st_next = SACC_IDLE;
                end else if (half_tick) begin
                    st_next = SACC_CONV;
                end
            end
            SACC_CONV: begin
                if (abort || go_clr || done) begin
                    st_next = SACC_IDLE;
                end else if (half_tick) begin
                    half_next = half_reg + 5'h01;
                    if (half_reg[0] && bit_reg != '0) begin
                        sar_next = comp_in_trial(sar_reg, bit_reg, cmp_s2_reg);
                        bit_next = bit_reg >> 1;
                    end
                end
            end
            default: st_next = SACC_IDLE;
        endcase
    end

    function automatic logic [RES_W-1:0] comp_in_trial(
        input logic [RES_W-1:0] acc,
        input logic [RES_W-1:0] b,
        input logic keep
    );
        comp_in_trial = keep ? (acc | b) : acc;
    endfunction

    // Stop loads result, partial bits repeat last decision
    assign res_next = (st_reg == SACC_CONV && st_next == SACC_IDLE && !srst)
                      ? fill_partial(sar_reg, bit_reg, cmp_s2_reg) : res_reg;

    function automatic logic [RES_W-1:0] fill_partial(
        input logic [RES_W-1:0] acc,
        input logic [RES_W-1:0] b,
        input logic last
    );
        logic [RES_W-1:0] mask;
        mask = b | (b - {{(RES_W-1){1'b0}}, 1'b1});
        if (b == '0) begin
            fill_partial = acc;
        end else begin
            fill_partial = last ? (acc | mask) : (acc & ~mask);
        end
    endfunction

    always_comb begin
        c0_next = c0_reg;
        if (wr0) begin
            c0_next = {1'b0, bus.wdata[6:2], bus.wdata[`SACC_B_GO] && bus.wdata[`SACC_B_ON]
                       && c0_reg[`SACC_B_ON], bus.wdata[`SACC_B_ON]};
        end
        if (st_reg != SACC_IDLE && st_next == SACC_IDLE) begin
            c0_next[`SACC_B_GO] = 1'b0;
        end
    end
    assign c1_next = wr1 ? {bus.wdata[7:4], 1'b0, 1'b0, bus.wdata[1:0]} : c1_reg;
    assign fv_next = wrf ? {bus.wdata[7], 1'b0, bus.wdata[5:0]} : fv_reg;
    // Set on every completion; cleared only by software, set wins
    assign flag_next = done || (wrp ? bus.wdata[`SACC_B_FLAG] : flag_reg);

    assign resh = c1_reg[`SACC_B_FM] ? {6'h00, res_reg[9:8]} : res_reg[9:2];
    assign resl = c1_reg[`SACC_B_FM] ? res_reg[7:0] : {res_reg[1:0], 6'h00};

    assign rd_mux = (bus.addr == `SACC_OFS_CTRL0) ? c0_reg :
                    (bus.addr == `SACC_OFS_CTRL1) ? c1_reg :
                    (bus.addr == `SACC_OFS_RESH) ? resh :
                    (bus.addr == `SACC_OFS_RESL) ? resl :
                    (bus.addr == `SACC_OFS_FVRC) ? {fv_reg[7], rdy_reg, fv_reg[5:0]} :
                    (bus.addr == `SACC_OFS_PFLAG) ? {1'b0, flag_reg, 6'h00} :
                    (bus.addr == `SACC_OFS_PEN) ? pe_reg :
                    (bus.addr == `SACC_OFS_INTC) ? ic_reg : 8'h00;

    assign analog_next.mux_en = c0_reg[`SACC_B_ON];
    // Channel code passes to the mux
    assign analog_next.chan = c0_reg[`SACC_B_CHS +: 5];
    assign analog_next.pref = c1_reg[`SACC_B_PREF +: 2];
    assign analog_next.buf_gain = fv_reg[`SACC_B_REFERENCE_ENABLE] ? fv_reg[1:0] : 2'h0;
    assign analog_next.ts_en = fv_reg[`SACC_B_TEMPERATURE_INDICATOR_ENABLE];
    assign analog_next.ts_high = fv_reg[`SACC_B_TEMPERATURE_RANGE_SELECT];

    always_ff @(posedge clk) begin
        cmp_s1_reg <= comp_in;
        cmp_s2_reg <= cmp_s1_reg;
        slp_s1_reg <= sleeping;
        slp_s2_reg <= slp_s1_reg;
        pin_s1_reg <= fvr_pin_ready;
        pin_s2_reg <= pin_s1_reg;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            c0_reg <= `SACC_RST_BYTE;
            c1_reg <= `SACC_RST_BYTE;
            fv_reg <= `SACC_RST_BYTE;
            pe_reg <= `SACC_RST_BYTE;
            ic_reg <= `SACC_RST_BYTE;
            flag_reg <= 1'b0;
            st_reg <= SACC_IDLE;
            half_reg <= 5'h00;
            sar_reg <= '0;
            bit_reg <= '0;
            res_reg <= '0;
        end else begin
            c0_reg <= c0_next;
            c1_reg <= c1_next;
            fv_reg <= fv_next;
            pe_reg <= wre ? bus.wdata : pe_reg;
            ic_reg <= wri ? bus.wdata : ic_reg;
            flag_reg <= flag_next;
            st_reg <= st_next;
            half_reg <= half_next;
            sar_reg <= sar_next;
            bit_reg <= bit_next;
            res_reg <= res_next;
        end
    end

    // Reference ready after settling time
    always_ff @(posedge clk) begin
        if (srst || !fv_reg[`SACC_B_REFERENCE_ENABLE]) begin
            rdy_cnt_reg <= 8'h00;
            rdy_reg <= 1'b0;
        end else if (rdy_cnt_reg != 8'(FVR_CYC)) begin
            rdy_cnt_reg <= rdy_cnt_reg + 8'h01;
        end else begin
            rdy_reg <= pin_s2_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
            analog <= '0;
            trial <= '0;
            sample <= 1'b0;
            int_req <= 1'b0;
            wake <= 1'b0;
            vector_req <= 1'b0;
        end else begin
            rdata <= bus.rd ? rd_mux : 8'h00;
            analog <= analog_next;
            trial <= sar_next | bit_next;
            sample <= (st_next == SACC_IDLE) && c0_next[`SACC_B_ON];
            int_req <= flag_next && (wre ? bus.wdata[`SACC_B_IE] : pe_reg[`SACC_B_IE]);
            // Wake on enabled completion in sleep
            wake <= slp_s2_reg && flag_next && pe_reg[`SACC_B_IE];
            // Vector only with all three enables
            vector_req <= flag_next && pe_reg[`SACC_B_IE] && ic_reg[`SACC_B_PERIPHERAL_INTERRUPT_ENABLE]
                          && ic_reg[`SACC_B_GIE];
        end
    end
endmodule
`default_nettype wire

/* File: design/sacc_defs.svh */
// Constants for the converter control block: offsets, field positions, resets, timing.
// Assumes a plain register port with byte-wide registers at word indices.
`ifndef SACC_DEFS_SVH
`define SACC_DEFS_SVH

`define SACC_OFS_CTRL0 4'h0
`define SACC_OFS_CTRL1 4'h1
`define SACC_OFS_RESH 4'h2
`define SACC_OFS_RESL 4'h3
`define SACC_OFS_FVRC 4'h4
`define SACC_OFS_PFLAG 4'h5
`define SACC_OFS_PEN 4'h6
`define SACC_OFS_INTC 4'h7

`define SACC_B_ON 0
`define SACC_B_GO 1
`define SACC_B_CHS 2
`define SACC_B_PREF 0
`define SACC_B_CS 4
`define SACC_B_FM 7
`define SACC_B_ADF 0
`define SACC_B_TEMPERATURE_RANGE_SELECT 4
`define SACC_B_TEMPERATURE_INDICATOR_ENABLE 5
`define SACC_B_RDY 6
`define SACC_B_REFERENCE_ENABLE 7
`define SACC_B_FLAG 6
`define SACC_B_IE 6
`define SACC_B_PERIPHERAL_INTERRUPT_ENABLE 6
`define SACC_B_GIE 7

`define SACC_RST_BYTE 8'h00
`define SACC_HALF_PERIODS 23
`define SACC_FVR_SETTLE_NS 1000
`define SACC_CLK_NS 10
`define SACC_RC_DIV 4

`endif

/* File: design/sacc_pkg.sv */
// Types shared by the converter control block.
// Assumes sacc_defs.svh supplies the numeric constants.
`default_nettype none
package sacc_pkg;
    typedef enum logic [2:0] {
        SACC_IDLE = 3'b001,
        SACC_WAIT = 3'b010,
        SACC_CONV = 3'b100
    } sacc_state_e;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sacc_bus_s;
    typedef struct packed {
        logic mux_en;
        logic [4:0] chan;
        logic [1:0] pref;
        logic [1:0] buf_gain;
        logic ts_en;
        logic ts_high;
    } sacc_analog_s;
endpackage
`default_nettype wire

/* File: design/sacc_clkgen.sv */
// Converter clock tick source: divided system clock or RC clock tick.
// Assumes rc_tick is a synchronous one-cycle pulse from the RC oscillator logic.
`default_nettype none
`include "sacc_defs.svh"
module sacc_clkgen
    import sacc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic [2:0] sel,
    input wire logic rc_tick,
    output logic half_tick
);
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic [5:0] half_div;
    logic use_rc;
    assign half_div = (sel == 3'h0) ? 6'h01 : (sel == 3'h4) ? 6'h02 :
                      (sel == 3'h1) ? 6'h04 : (sel == 3'h5) ? 6'h08 :
                      (sel == 3'h2) ? 6'h10 : 6'h20;
    assign use_rc = (sel[1:0] == 2'h3);
    assign cnt_next = (!run || cnt_reg + 6'h01 >= half_div) ? 6'h00 : cnt_reg + 6'h01;
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= 6'h00;
            half_tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            half_tick <= run && (use_rc ? rc_tick : (cnt_reg + 6'h01 >= half_div));
        end
    end
endmodule
`default_nettype wire

/* File: verif/sacc_ctrl_props.sv */
// Port assertions for the converter control block.
// Assumes bind to sacc_ctrl; mirrors of written registers are kept from the bus.
// Analog outputs lag a register write by one more cycle than the mirror.
`default_nettype none
`include "sacc_defs.svh"
module sacc_ctrl_props
    import sacc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire sacc_bus_s bus,
    input wire sacc_analog_s analog,
    input wire logic int_req,
    input wire logic wake,
    input wire logic vector_req
);
    logic [7:0] m_reg [8];
    logic [7:0] lag_reg [8];
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Mirror of last written control bytes
    always_ff @(posedge clk) begin
        if (srst) begin
            m_reg <= '{default: 8'h00};
            lag_reg <= '{default: 8'h00};
        end else begin
            lag_reg <= m_reg;
            if (bus.wr && !bus.addr[3]) begin
                m_reg[bus.addr[2:0]] <= bus.wdata;
            end
        end
    end
    ctl_reset_a: assert property (disable iff (1'h0) srst |=> analog == '0 && !int_req)
        else $error("outputs not clear after reset");
    mux_off_a: assert property (!lag_reg[0][0] |-> !analog.mux_en)
        else $error("multiplexer connected while converter off");
    chan_sel_a: assert property (analog.mux_en |-> analog.chan == lag_reg[0][6:2])
        else $error("channel differs from select field");
    pref_sel_a: assert property (analog.pref == lag_reg[1][1:0])
        else $error("positive reference differs from field");
    ts_on_a: assert property (analog.ts_en |-> lag_reg[4][5])
        else $error("temperature indicator on without enable");
    ts_range_a: assert property (analog.ts_en |-> analog.ts_high == lag_reg[4][4])
        else $error("temperature range differs from field");
    buf_gain_a: assert property (
        analog.buf_gain == (lag_reg[4][7] ? lag_reg[4][1:0] : 2'h0))
        else $error("buffer gain differs from field");
    int_en_a: assert property (int_req |-> m_reg[6][6])
        else $error("interrupt without converter enable");
    vec_req_a: assert property ($rose(vector_req) |-> m_reg[7][7] && m_reg[7][6])
        else $error("vector without global and peripheral enables");
    wake_en_a: assert property ($rose(wake) |-> m_reg[6][6])
        else $error("wake without converter enable");
endmodule
bind sacc_ctrl sacc_ctrl_props sacc_ctrl_props_inst (.clk(clk), .srst(srst), .bus(bus),
    .analog(analog), .int_req(int_req), .wake(wake), .vector_req(vector_req));
`default_nettype wire

/* File: verif/sacc_core_model.sv */
// Behavioural comparator core of the converter.
// Assumes the trial word stands a whole half period; slow adds a cycle of delay.
`default_nettype none
module sacc_core_model (
    input wire logic clk,
    input wire logic [9:0] trial,
    input wire logic [9:0] level,
    input wire logic slow,
    output logic comp_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fast_q;
    always_ff @(posedge clk) begin
        fast_q <= (trial <= level);
        comp_in <= slow ? fast_q : (trial <= level);
    end
endmodule
`default_nettype wire

/* File: verif/tb_sacc_ctrl.sv */
// Self-checking bench for the converter control block.
// Assumes the comparator model on the far side and a free-running RC tick.
`default_nettype none
module tb_sacc_ctrl;
    import sacc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic srst = 1'h1;
    sacc_bus_s bus = '0;
    logic [7:0] rdata;
    logic sleeping = 1'h0;
    logic rc_tick = 1'h0;
    logic comp_in;
    logic fvr_pin_ready = 1'h0;
    sacc_analog_s analog;
    logic [9:0] trial;
    logic sample;
    logic int_req;
    logic wake;
    logic vector_req;
    logic [9:0] level = 10'h2A5;
    logic slow = 1'h0;
    logic fmt = 1'h0;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        rc_tick <= ~rc_tick;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            report_and_stop();
        end
    end
    sacc_ctrl sacc_ctrl_inst (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
        .sleeping(sleeping), .rc_tick(rc_tick), .comp_in(comp_in),
        .fvr_pin_ready(fvr_pin_ready), .analog(analog), .trial(trial), .sample(sample),
        .int_req(int_req), .wake(wake), .vector_req(vector_req));
    sacc_core_model sacc_core_model_inst (.clk(clk), .trial(trial), .level(level),
        .slow(slow), .comp_in(comp_in));
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
        // Let outputs launched by the write settle before the caller looks
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    task automatic rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(what, {2'h0, exp}, {2'h0, d});
    endtask
    task automatic conv(input logic [2:0] cs, input logic ie, input logic sl, output int n);
        logic [7:0] d;
        wr(4'h6, {1'h0, ie, 6'h00});
        wr(4'h5, 8'h00);
        wr(4'h1, {fmt, cs, 4'h0});
        sleeping <= sl;
        repeat (8) @(posedge clk);
        wr(4'h0, 8'h0F);
        n = 0;
        d = 8'h02;
        while ((ie ? !int_req : d[1]) && n < 5000) begin
            if (ie) @(negedge clk);
            else rd(4'h0, d);
            n++;
        end
        @(posedge clk);
        check("completion", 10'h000, {9'h000, n >= 5000});
    endtask
    task automatic t_reset();
        for (int a = 0; a < 10; a++) rdchk("reset byte", a[3:0], 8'h00);
        check("analog reset lo", 10'h000, analog[9:0]);
        check("analog reset hi", 10'h000, {8'h00, analog[11:10]});
        $display("test reset done");
    endtask
    task automatic t_route();
        logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h0B, 5'h1D, 5'h1F};
        logic [1:0] prefs [3] = '{2'h0, 2'h2, 2'h3};
        foreach (codes[i]) begin
            wr(4'h0, {1'h0, codes[i], 2'h0});
            check("mux off", 10'h000, {9'h000, analog.mux_en});
            wr(4'h0, {1'h0, codes[i], 2'h1});
            check("mux chan", {5'h01, codes[i]}, {4'h0, analog.mux_en, analog.chan});
        end
        foreach (prefs[i]) begin
            wr(4'h1, {6'h00, prefs[i]});
            check("pref", {8'h00, prefs[i]}, {8'h00, analog.pref});
        end
        wr(4'h0, 8'h0D);
        rdchk("ctrl0", 4'h0, 8'h0D);
        $display("test route done");
    endtask
    task automatic t_ref();
        wr(4'h4, 8'hB1);
        check("ts on", 10'h007, {7'h00, analog.ts_en, analog.ts_high, 1'h1});
        check("gain1", 10'h001, {8'h00, analog.buf_gain});
        wr(4'h4, 8'h82);
        check("ts off", 10'h000, {8'h00, analog.ts_en, analog.ts_high});
        check("gain2", 10'h002, {8'h00, analog.buf_gain});
        repeat (150) @(posedge clk);
        rdchk("ref ready", 4'h4, 8'hC2);
        wr(4'h4, 8'h00);
        check("gain off", 10'h000, {8'h00, analog.buf_gain});
        $display("test reference done");
    endtask
    task automatic t_result();
        int n;
        for (int f = 0; f < 2; f++) begin
            fmt = f[0];
            // Divide by 2 is too fast for the synchronised comparator
            conv(3'h4, 1'h0, 1'h0, n);
            rdchk("flag", 4'h5, 8'h40);
            rdchk("res hi", 4'h2, fmt ? {6'h00, level[9:8]} : level[9:2]);
            rdchk("res lo", 4'h3, fmt ? level[7:0] : {level[1:0], 6'h00});
            rdchk("flag kept", 4'h5, 8'h40);
        end
        $display("test result done");
    endtask
    task automatic t_clock();
        logic [2:0] cs [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
        int n0;
        int n;
        for (int k = 0; k < 6; k++) begin
            slow <= (k == 3);
            conv(cs[k], 1'h1, 1'h0, n);
            if (k == 0) n0 = n;
            check("duration", 10'((23 << k) - 23), 10'(n - n0));
        end
        wr(4'h5, 8'h00);
        check("int cleared", 10'h000, {9'h000, int_req});
        slow <= 1'h0;
        $display("test clock done");
    endtask
    task automatic t_sleep();
        int n;
        for (int g = 0; g < 2; g++) begin
            wr(4'h7, {g[0], 7'h40});
            conv(3'h3, 1'h1, 1'h1, n);
            check("wake", 10'h001, {9'h000, wake});
            check("vector", 10'(g), {9'h000, vector_req});
            sleeping <= 1'h0;
            rdchk("sleep res", 4'h3, level[7:0]);
        end
        wr(4'h5, 8'h00);
        wr(4'h1, {fmt, 3'h0, 4'h0});
        sleeping <= 1'h1;
        wr(4'h0, 8'h0F);
        repeat (40) @(posedge clk);
        rdchk("abort go", 4'h0, 8'h0D);
        rdchk("abort flag", 4'h5, 8'h00);
        check("abort wake", 10'h000, {9'h000, wake});
        sleeping <= 1'h0;
        $display("test sleep done");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'h0;
        fvr_pin_ready <= 1'h1;
        @(posedge clk);
        t_reset();
        t_route();
        t_ref();
        t_result();
        t_clock();
        t_sleep();
        report_and_stop();
    end
endmodule
`default_nettype wire
